// ===== verilog/spmf_consts.svh
// constants for the scratchpad memory-function slave and its bus master
// Contract
// R1 - every byte travels least significant bit first
// R2 - identity: family, 48-bit serial, check byte
// R3 - check byte uses polynomial x8+x5+x4+1
// R4 - check starts zero, family LSB first, 56 bits
// R5 - receiver accepts code when check reads zero
// R6 - 256 pages of 32 bytes plus scratchpad
// R7 - target address low and high byte registers
// R8 - status register is read-only to master
// R9 - status low bits hold last written offset
// R10 - bit 5 flags partial final byte
// R11 - bit 6 flags scratchpad overflow
// R12 - writes start at target address offset
// R13 - top bit marks copy done, write clears
// R14 - write command: address low, high, data
// R15 - read command: address, status, data, ones
// R16 - copy needs address and status echoed back
// R17 - memory commands need identity selection first
// R18 - master treats set flags as failed write
// R19 - master prefers page-aligned write addresses
// R20 - matching copy sets flag, copies, sends zeros
// R21 - memory read streams to end, then ones
// R22 - identity commands 33, 55, CC, F0
// R23 - mismatched copy pattern changes nothing
// R24 - write command clears partial and overflow
`ifndef SPMF_CONSTS_SVH
`define SPMF_CONSTS_SVH
`define SPMF_CMD_READ_ID    8'h33
`define SPMF_CMD_MATCH_ID   8'h55
`define SPMF_CMD_SKIP_ID    8'hCC
`define SPMF_CMD_SEARCH_ID  8'hF0
`define SPMF_CMD_WRITE_SP   8'h0F
`define SPMF_CMD_READ_SP    8'hAA
`define SPMF_CMD_COPY_SP    8'h55
`define SPMF_CMD_READ_MEM   8'hF0
`define SPMF_CRC_POLY       8'h8C
`define SPMF_MEM_BYTES      8192
`define SPMF_SP_BYTES       32
`define SPMF_ST_PF_BIT      5
`define SPMF_ST_OF_BIT      6
`define SPMF_ST_AA_BIT      7
`define SPMF_REG_CMD        4'h0
`define SPMF_REG_STATUS     4'h4
`define SPMF_REG_CRC        4'h8
`define SPMF_OP_RESET       3'h0
`define SPMF_OP_WR_BYTE     3'h1
`define SPMF_OP_RD_BYTE     3'h2
`define SPMF_OP_WR_BIT      3'h3
`define SPMF_OP_RD_BIT      3'h4
`endif

// ===== verilog/spmf_pkg.sv
// types and check-byte arithmetic shared by both ends
package spmf_pkg;
  `include "spmf_consts.svh"

  typedef enum logic [4:0] {
    ST_IDLE, ST_ROM_CMD, ST_READ_ROM, ST_MATCH, ST_SEARCH, ST_MEM_CMD,
    ST_TA1, ST_TA2, ST_WR_DATA, ST_SP_TA1, ST_SP_TA2, ST_SP_ES, ST_SP_DATA,
    ST_CP_TA1, ST_CP_TA2, ST_CP_ES, ST_COPY, ST_ZEROS, ST_RD_DATA
  } spmf_dev_state_e;

  typedef enum logic [1:0] {M_IDLE, M_RESET, M_SLOT, M_CAP} spmf_mst_state_e;

  // one shift of the check generator, reflected form of x8+x5+x4+1
  function automatic logic [7:0] spmf_crc_step(input logic [7:0] crc, input logic b);
    logic [7:0] nxt;
    nxt = {1'b0, crc[7:1]};
    if (crc[0] ^ b)
      nxt = nxt ^ `SPMF_CRC_POLY;
    return nxt;
  endfunction

  // check byte over 56 identity bits, bit 0 first
  function automatic logic [7:0] spmf_crc56(input logic [55:0] id);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 0; i < 56; i++)
      crc = spmf_crc_step(crc, id[i]);
    return crc;
  endfunction
endpackage

// ===== verilog/spmf_link_if.sv
// bit-slot link between the bus master and the memory slave
`timescale 1ns/1ps
interface spmf_link_if;
  logic trst;     // transaction reset pulse, master
  logic slot;     // time slot pulse, master
  logic slot_wr;  // slot carries a master bit
  logic wbit;     // master bit value
  logic rbit;     // slave bit, valid the cycle after a read slot
  logic busy;     // slave copying, resets ignored

  modport mst (output trst, output slot, output slot_wr, output wbit,
               input rbit, input busy);
  modport dev (input trst, input slot, input slot_wr, input wbit,
               output rbit, output busy);
endinterface

// ===== verilog/spmf_device.sv
// scratchpad memory-function slave: identity, scratchpad, memory and copy
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
module spmf_device
  import spmf_pkg::*;
#(
  parameter logic [7:0]  FAMILY = 8'h5A,           // arbitrary value
  parameter logic [47:0] SERIAL = 48'h123456789ABC // arbitrary value
)(
  input  wire logic   CLOCK_I,    // system clock
  input  wire logic   SRST_I,     // synchronous reset
  spmf_link_if.dev    LINK,       // link to the master
  output logic [7:0]  STATUS_O,   // ending offset and status byte
  output logic        SELECTED_O  // memory functions reachable
);
  localparam logic [55:0] ID56 = {SERIAL, FAMILY};
  localparam logic [63:0] ROM  = {spmf_crc56(ID56), ID56}; // R2 R4

  spmf_dev_state_e state_reg;
  logic [2:0]      bit_reg;
  logic [5:0]      idx_reg;
  logic [1:0]      step_reg;
  logic [7:0]      rx_reg;
  logic [7:0]      cmd_reg;
  logic [15:0]     ta_reg;
  logic [5:0]      ptr_reg;
  logic [16:0]     maddr_reg;
  logic            auth_reg;
  logic [4:0]      end_reg;
  logic            pf_reg;
  logic            of_reg;
  logic            aa_reg;
  logic            rbit_reg;
  logic            busy_reg;
  logic            sel_reg;
  logic [7:0]      sp_mem [0:`SPMF_SP_BYTES-1];
  logic [7:0]      mem    [0:`SPMF_MEM_BYTES-1];

  logic       wslot;
  logic       rslot;
  logic       byte_done;
  logic       rbyte_done;
  logic [7:0] rx_byte;
  logic [7:0] es_byte;
  logic [7:0] tx_byte;
  logic       tx_bit;
  logic       id_bit;
  logic       wr_start;
  logic       cp_match;

  // slot decode; bytes assemble from the top so bit 0 arrives first
  assign wslot      = LINK.slot & LINK.slot_wr;
  assign rslot      = LINK.slot & ~LINK.slot_wr;
  assign byte_done  = wslot & (bit_reg == 3'h7);
  assign rbyte_done = rslot & (bit_reg == 3'h7);
  assign rx_byte    = {LINK.wbit, rx_reg[7:1]}; // R1
  assign es_byte    = {aa_reg, of_reg, pf_reg, end_reg};
  assign id_bit     = ROM[idx_reg];
  assign wr_start   = (state_reg == ST_TA2) & byte_done & (cmd_reg == `SPMF_CMD_WRITE_SP);
  assign cp_match   = (state_reg == ST_CP_ES) & byte_done & auth_reg & (rx_byte == es_byte);

  // byte offered in the read-back and memory streams, ones past the end
  always_comb
  begin
    tx_byte = 8'hFF;
    if (state_reg == ST_SP_TA1)
      tx_byte = ta_reg[7:0];
    else if (state_reg == ST_SP_TA2)
      tx_byte = ta_reg[15:8];
    else if (state_reg == ST_SP_ES)
      tx_byte = es_byte;
    else if (state_reg == ST_SP_DATA && !ptr_reg[5])
      tx_byte = sp_mem[ptr_reg[4:0]]; // R15
    else if (state_reg == ST_RD_DATA && maddr_reg[16:13] == 4'h0)
      tx_byte = mem[maddr_reg[12:0]]; // R21
  end

  // bit answered in a read slot; idle states leave the line high
  always_comb
  begin
    tx_bit = 1'b1;
    if (state_reg == ST_READ_ROM)
      tx_bit = id_bit;
    else if (state_reg == ST_SEARCH)
      tx_bit = (step_reg == 2'h1) ? ~id_bit : id_bit;
    else if (state_reg == ST_ZEROS || state_reg == ST_COPY)
      tx_bit = 1'b0; // R20
    else
      tx_bit = tx_byte[bit_reg]; // R1
  end

  // command interpreter
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      state_reg <= ST_IDLE;
      bit_reg   <= 3'h0;
      idx_reg   <= 6'h00;
      step_reg  <= 2'h0;
      rx_reg    <= 8'h00;
      cmd_reg   <= 8'h00;
      ta_reg    <= 16'h0000;
      ptr_reg   <= 6'h00;
      maddr_reg <= 17'h00000;
      auth_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      sel_reg   <= 1'b0;
    end
    else if (LINK.trst && state_reg != ST_COPY) // R20
    begin
      state_reg <= ST_ROM_CMD;
      bit_reg   <= 3'h0;
      idx_reg   <= 6'h00;
      step_reg  <= 2'h0;
      sel_reg   <= 1'b0;
    end
    else
    begin
      if (LINK.slot)
        bit_reg <= bit_reg + 3'h1;
      if (wslot)
        rx_reg <= rx_byte;
      unique case (state_reg)
        ST_IDLE, ST_ZEROS:
        begin
        end
        // offset stops one past the end so later bits only raise overflow
        ST_WR_DATA:
          if (byte_done && !ptr_reg[5])
            ptr_reg <= ptr_reg + 6'h01; // R12
        ST_ROM_CMD:
          if (byte_done)
          begin
            // R22
            if (rx_byte == `SPMF_CMD_READ_ID)
              state_reg <= ST_READ_ROM;
            else if (rx_byte == `SPMF_CMD_MATCH_ID)
              state_reg <= ST_MATCH;
            else if (rx_byte == `SPMF_CMD_SKIP_ID)
              state_reg <= ST_MEM_CMD;
            else if (rx_byte == `SPMF_CMD_SEARCH_ID)
              state_reg <= ST_SEARCH;
            else
              state_reg <= ST_IDLE;
          end
        ST_READ_ROM:
          if (rslot)
          begin
            idx_reg <= idx_reg + 6'h01;
            if (idx_reg == 6'h3F)
              state_reg <= ST_MEM_CMD;
          end
        ST_MATCH:
          if (wslot)
          begin
            idx_reg <= idx_reg + 6'h01;
            if (LINK.wbit != id_bit)
              state_reg <= ST_IDLE;
            else if (idx_reg == 6'h3F)
              state_reg <= ST_MEM_CMD;
          end
        ST_SEARCH:
          if (step_reg != 2'h2 && rslot)
            step_reg <= step_reg + 2'h1;
          else if (step_reg == 2'h2 && wslot)
          begin
            step_reg <= 2'h0;
            idx_reg  <= idx_reg + 6'h01;
            if (LINK.wbit != id_bit)
              state_reg <= ST_IDLE;
            else if (idx_reg == 6'h3F)
              state_reg <= ST_MEM_CMD;
          end
        ST_MEM_CMD:
          if (byte_done)
          begin
            cmd_reg <= rx_byte;
            if (rx_byte == `SPMF_CMD_WRITE_SP || rx_byte == `SPMF_CMD_READ_MEM)
              state_reg <= ST_TA1; // R14
            else if (rx_byte == `SPMF_CMD_READ_SP)
              state_reg <= ST_SP_TA1;
            else if (rx_byte == `SPMF_CMD_COPY_SP)
              state_reg <= ST_CP_TA1;
            else
              state_reg <= ST_IDLE;
          end
        ST_TA1:
          if (byte_done)
          begin
            ta_reg[7:0] <= rx_byte; // R7
            state_reg   <= ST_TA2;
          end
        ST_TA2:
          if (byte_done)
          begin
            ta_reg[15:8] <= rx_byte;
            ptr_reg      <= {1'b0, ta_reg[4:0]}; // R12
            maddr_reg    <= {1'b0, rx_byte, ta_reg[7:0]};
            state_reg    <= wr_start ? ST_WR_DATA : ST_RD_DATA;
          end
        ST_SP_TA1:
          if (rbyte_done)
            state_reg <= ST_SP_TA2;
        ST_SP_TA2:
          if (rbyte_done)
            state_reg <= ST_SP_ES;
        ST_SP_ES:
          if (rbyte_done)
          begin
            ptr_reg   <= {1'b0, ta_reg[4:0]};
            state_reg <= ST_SP_DATA;
          end
        ST_SP_DATA:
          if (rbyte_done && !ptr_reg[5])
            ptr_reg <= ptr_reg + 6'h01;
        ST_RD_DATA:
          if (rbyte_done && maddr_reg[16:13] == 4'h0)
            maddr_reg <= maddr_reg + 17'h00001;
        ST_CP_TA1:
          if (byte_done)
          begin
            auth_reg  <= (rx_byte == ta_reg[7:0]); // R16
            state_reg <= ST_CP_TA2;
          end
        ST_CP_TA2:
          if (byte_done)
          begin
            auth_reg  <= auth_reg & (rx_byte == ta_reg[15:8]);
            state_reg <= ST_CP_ES;
          end
        ST_CP_ES:
          if (byte_done)
          begin
            ptr_reg   <= {1'b0, ta_reg[4:0]};
            busy_reg  <= cp_match;
            state_reg <= cp_match ? ST_COPY : ST_IDLE; // R23
          end
        ST_COPY:
          if (ptr_reg[4:0] == end_reg)
          begin
            busy_reg  <= 1'b0;
            state_reg <= ST_ZEROS; // R20
          end
          else
            ptr_reg <= ptr_reg + 6'h01;
      endcase
      // alignment restarts at the memory command; selection is now done
      if ((state_reg == ST_READ_ROM && rslot && idx_reg == 6'h3F) ||
          ((state_reg == ST_MATCH || (state_reg == ST_SEARCH && step_reg == 2'h2)) &&
           wslot && idx_reg == 6'h3F && LINK.wbit == id_bit) ||
          (state_reg == ST_ROM_CMD && byte_done && rx_byte == `SPMF_CMD_SKIP_ID))
      begin
        bit_reg <= 3'h0;
        sel_reg <= 1'b1; // R17
      end
    end
  end

  // status flags; only the slave's own logic changes them
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      end_reg <= 5'h00;
      pf_reg  <= 1'b0;
      of_reg  <= 1'b0;
      aa_reg  <= 1'b0;
    end
    else if (wr_start)
    begin
      pf_reg <= 1'b0; // R24
      of_reg <= 1'b0;
      aa_reg <= 1'b0; // R13
    end
    else if (state_reg == ST_WR_DATA && wslot)
    begin
      if (ptr_reg[5])
        of_reg <= 1'b1; // R11
      else
      begin
        end_reg <= ptr_reg[4:0];       // R9 R8
        pf_reg  <= (bit_reg != 3'h7);  // R10
      end
    end
    else if (cp_match)
      aa_reg <= 1'b1; // R20
  end

  // scratchpad: written bit by bit so a partial byte keeps its bits
  always_ff @(posedge CLOCK_I)
  begin
    if (state_reg == ST_WR_DATA && wslot && !ptr_reg[5])
      sp_mem[ptr_reg[4:0]][bit_reg] <= LINK.wbit; // R12 R14
  end

  // main memory: one whole byte per cycle during copy, page from target
  always_ff @(posedge CLOCK_I)
  begin
    if (state_reg == ST_COPY)
      mem[{ta_reg[12:5], ptr_reg[4:0]}] <= sp_mem[ptr_reg[4:0]]; // R6 R20
  end

  // link answers and user outputs, all registered
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      rbit_reg   <= 1'b1;
      STATUS_O   <= 8'h00;
      SELECTED_O <= 1'b0;
    end
    else
    begin
      rbit_reg   <= rslot ? tx_bit : 1'b1;
      STATUS_O   <= es_byte;
      SELECTED_O <= sel_reg;
    end
  end

  assign LINK.rbit = rbit_reg;
  assign LINK.busy = busy_reg;
endmodule

// ===== verilog/spmf_master.sv
// bus master: turns register commands into reset, write and read slots
`timescale 1ns/1ps
module spmf_master
  import spmf_pkg::*;
(
  input  wire logic        CLOCK_I,  // system clock
  input  wire logic        SRST_I,   // synchronous reset
  input  wire logic [3:0]  ADDR_I,   // register byte address
  input  wire logic [31:0] WDATA_I,  // write data
  input  wire logic        WR_I,     // write strobe
  input  wire logic        RD_I,     // read strobe
  output logic [31:0]      RDATA_O,  // read data, cycle after strobe
  spmf_link_if.mst         LINK      // link to the slave
);
  spmf_mst_state_e state_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic       wr_reg;
  logic       trst_reg;
  logic       slot_reg;
  logic [7:0] crc_reg;
  logic       cmd_take;
  logic [2:0] op;

  assign op       = WDATA_I[10:8];
  assign cmd_take = WR_I & (ADDR_I == `SPMF_REG_CMD) & (state_reg == M_IDLE);

  // slot sequencer; commands while busy are dropped
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      state_reg <= M_IDLE;
      sh_reg    <= 8'h00;
      cnt_reg   <= 4'h0;
      wr_reg    <= 1'b0;
      trst_reg  <= 1'b0;
      slot_reg  <= 1'b0;
    end
    else
    begin
      trst_reg <= 1'b0;
      slot_reg <= 1'b0;
      unique case (state_reg)
        M_IDLE:
          if (cmd_take)
          begin
            sh_reg  <= WDATA_I[7:0];
            wr_reg  <= (op == `SPMF_OP_WR_BYTE) || (op == `SPMF_OP_WR_BIT);
            cnt_reg <= (op == `SPMF_OP_WR_BIT || op == `SPMF_OP_RD_BIT) ? 4'h1 : 4'h8;
            if (op == `SPMF_OP_RESET)
            begin
              trst_reg  <= 1'b1;
              state_reg <= M_RESET;
            end
            else
            begin
              slot_reg  <= 1'b1;
              state_reg <= M_SLOT;
            end
          end
        M_RESET:
          state_reg <= M_IDLE;
        M_SLOT:
          state_reg <= M_CAP;
        M_CAP:
        begin
          sh_reg  <= {LINK.rbit, sh_reg[7:1]}; // R1
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1)
            state_reg <= M_IDLE;
          else
          begin
            slot_reg  <= 1'b1;
            state_reg <= M_SLOT;
          end
        end
      endcase
    end
  end

  // running check over received bits; an update wins over a clear
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
      crc_reg <= 8'h00;
    else if (state_reg == M_CAP && !wr_reg)
      crc_reg <= spmf_crc_step(crc_reg, LINK.rbit); // R3 R4 R5
    else if (WR_I && ADDR_I == `SPMF_REG_CRC)
      crc_reg <= 8'h00;
  end

  // register reads; software checks status flags before copying
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
      RDATA_O <= 32'h00000000;
    else if (RD_I && ADDR_I == `SPMF_REG_STATUS)
      RDATA_O <= {16'h0000, sh_reg, 5'h00, LINK.busy, (crc_reg == 8'h00),
                  (state_reg != M_IDLE)}; // R5
    else if (RD_I && ADDR_I == `SPMF_REG_CRC)
      RDATA_O <= {24'h000000, crc_reg};
    else
      RDATA_O <= 32'h00000000;
  end

  assign LINK.trst    = trst_reg;
  assign LINK.slot    = slot_reg;
  assign LINK.slot_wr = wr_reg;
  assign LINK.wbit    = sh_reg[0];
endmodule

// ===== sim/spmf_link_assertions.sv
// link protocol checker between the bus master and the memory slave
`timescale 1ns/1ps
module spmf_link_assertions (
  input wire logic CLOCK_I, // system clock
  input wire logic SRST_I,  // synchronous reset
  input wire logic trst,    // transaction reset pulse
  input wire logic slot,    // time slot pulse
  input wire logic slot_wr, // master bit slot
  input wire logic wbit,    // master bit value
  input wire logic rbit,    // slave bit
  input wire logic busy     // slave copying
);
  logic copied_reg;
  logic last_wr_reg;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SRST_I);

  // a finished copy keeps answering zeros until the next transaction reset
  always_ff @(posedge CLOCK_I)
    if (SRST_I || trst)
      copied_reg <= 1'b0;
    else if ($fell(busy))
      copied_reg <= 1'b1;

  // kind of the latest slot, so a copy can be tied to the bytes before it
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
      last_wr_reg <= 1'b0;
    else if (slot)
      last_wr_reg <= slot_wr;

  sequence s_read_slot;
    slot && !slot_wr;
  endsequence
  sequence s_write_slot;
    slot && slot_wr;
  endsequence

  a_rbit_idle_one: assert property (!$past(slot) |-> rbit)
    else $error("slave bit low without a read slot");
  a_slot_one_cycle: assert property (slot |=> !slot)
    else $error("slot pulse longer than one cycle");
  a_trst_one_cycle: assert property (trst |=> !trst)
    else $error("transaction reset longer than one cycle");
  a_trst_not_slot: assert property (!(trst && slot))
    else $error("reset and slot in one cycle");
  a_copy_bounded: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("copy did not end in time");
  a_copy_after_write: assert property ($rose(busy) |-> last_wr_reg)
    else $error("copy started without echoed bytes");
  a_zeros_after_copy: assert property (copied_reg ##0 s_read_slot |=> !rbit)
    else $error("slave bit high after a copy");
  a_write_slot_quiet: assert property (s_write_slot |=> rbit)
    else $error("slave answered a write slot");
  c_copy_seen: cover property ($fell(busy) ##[1:300] s_read_slot);
  c_one_sent: cover property (s_write_slot ##0 wbit);
endmodule

// ===== sim/scratchpad_memory_functions_tb.sv
// self-checking bench: master and slave joined over the bit-slot link
`timescale 1ns/1ps
module scratchpad_memory_functions_tb;
  import spmf_pkg::*;
  localparam logic [7:0]  FAM = 8'h3C;            // arbitrary value
  localparam logic [47:0] SER = 48'hA1B2C3D4E5F6; // arbitrary value
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic [63:0] idc;
  logic [7:0]  st;
  logic        sel;
  int          n_errors = 0;
  int          checked = 0;

  spmf_link_if lnk ();
  spmf_master u_spmf_master (.CLOCK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LINK(lnk.mst));
  spmf_device #(.FAMILY(FAM), .SERIAL(SER)) u_spmf_device (.CLOCK_I(clk), .SRST_I(srst),
    .LINK(lnk.dev), .STATUS_O(st), .SELECTED_O(sel));
  spmf_link_assertions u_spmf_link_assertions (.CLOCK_I(clk), .SRST_I(srst), .trst(lnk.trst),
    .slot(lnk.slot), .slot_wr(lnk.slot_wr), .wbit(lnk.wbit), .rbit(lnk.rbit), .busy(lnk.busy));

  // 10 MHz system clock
  always #50 clk = ~clk;

  task automatic print_verdict();
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one strobe cycle; read data is taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // issue a link operation, then poll until master and copy are both idle
  task automatic op(input logic [2:0] o, input logic [7:0] d);
    bus(1'b1, 4'h0, {21'h0, o, d});
    for (int i = 0; i < 80; i++)
    begin
      bus(1'b0, 4'h4, 32'h0);
      if (rv[0] === 1'b0 && rv[2] === 1'b0)
        return;
    end
    n_errors++;
    print_verdict();
  endtask

  task automatic wb(input logic [7:0] d);
    op(3'h1, d);
  endtask

  task automatic rb(output logic [7:0] d);
    op(3'h2, 8'h00);
    d = rv[15:8];
  endtask

  task automatic start(input logic [7:0] cmd);
    op(3'h0, 8'h00);
    wb(8'hCC);
    wb(cmd);
  endtask

  task automatic rseq(input logic [63:0] e, input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++)
    begin
      rb(b);
      chk(b, e[8*i +: 8]);
    end
  endtask

  // identity read with the check byte worked out bit by bit here
  task automatic t_rom();
    logic [7:0] c;
    logic [7:0] b;
    idc = {8'h00, SER, FAM};
    c = 8'h00;
    for (int i = 0; i < 56; i++)
      c = (c >> 1) ^ (((c[0] ^ idc[i]) == 1'b1) ? 8'h8C : 8'h00);
    idc[63:56] = c;
    op(3'h0, 8'h00);
    wb(8'h33);
    bus(1'b1, 4'h8, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      rb(b);
      chk(b, idc[8*i +: 8]);
    end
    bus(1'b0, 4'h8, 32'h0);
    chk(rv[7:0], 8'h00);
    chk(sel, 1'b1);
  endtask

  // no selection, a wrong and a right match, then a full search pass
  task automatic t_sel();
    logic [7:0] b;
    op(3'h0, 8'h00);
    wb(8'hAA);
    chk(sel, 1'b0);
    rb(b);
    chk(b, 8'hFF);
    for (int k = 0; k < 2; k++)
    begin
      op(3'h0, 8'h00);
      wb(8'h55);
      for (int i = 0; i < 8; i++)
        wb(idc[8*i +: 8] ^ {7'h0, k == 0 && i == 3});
      chk(sel, k[0]);
    end
    op(3'h0, 8'h00);
    wb(8'hF0);
    for (int i = 0; i < 64; i++)
    begin
      op(3'h4, 8'h00);
      chk(rv[15], idc[i]);
      op(3'h4, 8'h00);
      chk(rv[15], !idc[i]);
      op(3'h3, {7'h0, idc[i]});
    end
    chk(sel, 1'b1);
  endtask

  // write, read back, refused copy, accepted copy, memory read
  task automatic t_copy();
    logic [7:0] b;
    start(8'h0F);
    wb(8'h26);
    wb(8'h00);
    wb(8'hA5);
    wb(8'h3C);
    chk(st, 8'h07);
    start(8'hAA);
    rseq({16'h3CA5, 8'h07, 8'h00, 8'h26}, 5);
    start(8'h55);
    wb(8'h26);
    wb(8'h00);
    wb(8'h06);
    chk(st, 8'h07);
    start(8'h55);
    wb(8'h26);
    wb(8'h00);
    wb(8'h07);
    chk(st, 8'h87);
    rb(b);
    chk(b, 8'h00);
    start(8'hF0);
    wb(8'h26);
    wb(8'h00);
    rseq(64'h3CA5, 2);
    chk(st, 8'h87);
    start(8'hF0);
    wb(8'hFF);
    wb(8'h1F);
    rb(b);
    rb(b);
    chk(b, 8'hFF);
  endtask

  // write past the scratchpad end from offset 1C, then a partial byte
  task automatic t_over();
    start(8'h0F);
    wb(8'h3C);
    wb(8'h01);
    for (int i = 0; i < 5; i++)
      wb(i[7:0]);
    chk(st, 8'h5F);
    start(8'hAA);
    rseq(64'hFF03020100_5F013C, 8);
    start(8'h0F);
    wb(8'h00);
    wb(8'h00);
    wb(8'hAB);
    for (int i = 0; i < 3; i++)
      op(3'h3, 8'h01);
    chk(st[6:5], 2'b01);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_rom();
    t_sel();
    t_copy();
    t_over();
    print_verdict();
  end
endmodule
